// >>> bench/irq_core_model.sv
// Purpose: core sequencer stand-in that stacks the return address
// Assumes: one hardware call at a time
// Notes:   return address moves on after each vector load
`timescale 1ns/10ps
module irq_core_model (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire irq_ctrl_pkg::call_bus_t call_i,
  input  wire logic                    ret_i,
  output logic [15:0]                  pc_o,
  output logic                         isr_exit_o,
  output logic [15:0]                  stack_o
);
  import irq_ctrl_pkg::*;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pc_o <= 16'h2A51;
      stack_o <= 16'h0000;
    end else begin
      if (call_i.push) stack_o <= {call_i.push_data, stack_o[15:8]};
      if (call_i.pc_load) pc_o <= pc_o + 16'h1357;
    end
  end
  // Plain returns never reach the controller
  always_ff @(posedge clk_i) isr_exit_o <= reset_n_i && ret_i;
endmodule

// >>> bench/two_level_vectored_irq_ctrl_chk.sv
// Purpose: port-level checks of the vectored interrupt controller
// Assumes: core holds pc_i steady during a call
// Notes:   bound onto every controller instance
`timescale 1ns/10ps
module irq_chk (
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    last_cycle_i,
  input wire logic                    blocking_instr_i,
  input wire logic                    isr_exit_i,
  input wire logic [15:0]             pc_i,
  input wire logic [1:0]              mc_phase_o,
  input wire irq_ctrl_pkg::call_bus_t call_o,
  input wire logic                    call_busy_o,
  input wire logic [1:0]              in_service_o
);
  import irq_ctrl_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================================
  // Hardware call
  call_seq_a: assert property ($rose(call_busy_o) |-> ##[1:4]
    (call_o.push && call_o.push_data == pc_i[7:0]) ##4
    (call_o.push && call_o.push_data == pc_i[15:8])) else $error("push sequence wrong");
  load_end_a: assert property (call_o.pc_load |-> $past(call_o.push, 8) && !call_busy_o)
    else $error("vector load out of place");
  vec_form_a: assert property (call_o.pc_load |-> call_o.pc_value[2:0] == 3'h3
    && call_o.pc_value <= 16'h0063 && call_o.pc_value != 16'h0033) else $error("bad vector");
  push_in_call_a: assert property (call_o.push |-> call_busy_o)
    else $error("push outside call");
  // ==========================================================================
  // Take conditions and levels
  take_gate_a: assert property ($rose(call_busy_o) |-> $past(last_cycle_i)
    && !$past(blocking_instr_i) && !$past(isr_exit_i) && $past(mc_phase_o) == PHASE_LAST)
    else $error("call taken while barred");
  level_rule_a: assert property ($rose(call_busy_o) |-> !$past(in_service_o[1])
    && in_service_o != $past(in_service_o)) else $error("level rule broken");
  exit_free_a: assert property (isr_exit_i |=> in_service_o ==
    ($past(in_service_o[1]) ? {1'b0, $past(in_service_o[0])} : 2'h0))
    else $error("exit release wrong");
  phase_step_a: assert property ($past(reset_n_i) && $past(reset_n_i, 2) |->
    mc_phase_o == 2'($past(mc_phase_o) + 2'h1)) else $error("phase count wrong");
  take_c: cover property ($rose(call_busy_o));
  exit_c: cover property (isr_exit_i && in_service_o[1]);
  nest_c: cover property ($rose(in_service_o[1]) && in_service_o[0]);
endmodule
bind two_level_vectored_irq_ctrl irq_chk chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .last_cycle_i(last_cycle_i), .blocking_instr_i(blocking_instr_i), .isr_exit_i(isr_exit_i),
  .pc_i(pc_i), .mc_phase_o(mc_phase_o), .call_o(call_o), .call_busy_o(call_busy_o),
  .in_service_o(in_service_o));

// >>> bench/two_level_vectored_irq_ctrl_tb_top.sv
// Purpose: self-checking bench of the vectored interrupt controller
// Assumes: core model answers every hardware call
// Notes:   most sources are raised by flag writes
`timescale 1ns/10ps
module two_level_vectored_irq_ctrl_tb_top;
  import irq_ctrl_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, last = 1, blk = 0, ret = 0;
  logic [2:0]  addr = 0;
  logic [15:0] wdata = 0, rdata, pc, stk;
  logic [5:0]  pins = 6'h3F;
  logic [1:0]  phase, insvc;
  logic        busy, exitw;
  flag_set_t   fset = '0;
  call_bus_t   call;
  int          err_total = 0, n_compared = 0, cyc = 0, calls = 0;
  int          fbit [12] = '{0, 6, 1, 7, 11, 9, 12, 2, 3, 4, 5, 14};
  two_level_vectored_irq_ctrl uut (.clk_i(clk), .reset_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_irq_pin_n_i(pins),
    .flag_set_i(fset), .last_cycle_i(last), .blocking_instr_i(blk), .isr_exit_i(exitw),
    .pc_i(pc), .mc_phase_o(phase), .call_o(call), .call_busy_o(busy), .in_service_o(insvc));
  irq_core_model core (.clk_i(clk), .reset_n_i(rst_n), .call_i(call), .ret_i(ret),
    .pc_o(pc), .isr_exit_o(exitw), .stack_o(stk));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (call.pc_load) calls <= calls + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task automatic serve(input logic [15:0] v);
    logic [15:0] p;
    int n;
    p = pc;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (call.pc_load !== 1'b1 && n < 60);
    chk(call.pc_value, v);
    chk(stk, p);
    chk(16'(n <= MAX_LATENCY_CLKS), 16'h0001);
  endtask
  task automatic isr_ret();
    @(posedge clk);
    ret <= 1;
    @(posedge clk);
    ret <= 0;
  endtask
  task automatic idle_chk(input logic [15:0] got_now, input logic [15:0] e);
    repeat (40) @(posedge clk);
    #1 chk(got_now === 16'hFFFF ? 16'(insvc) : 16'(calls), e);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] fl;
    int c0;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int a = 0; a < 6; a++) rd_chk(3'(a), 16'h0000);
    wr_reg(ADDR_TRIG, 16'h0003);
    wr_reg(ADDR_ENABLE, 16'h8FFF);
    fl = 16'h0000;
    for (int i = 0; i < 12; i++) fl[fbit[i]] = 1'b1;
    wr_reg(ADDR_FLAGS, fl);
    for (int i = 0; i < 12; i++) begin
      serve(VECTOR_TABLE[i]);
      if (i < 4) fl[fbit[i]] = 1'b0;
      rd_chk(ADDR_FLAGS, fl);
      fl[fbit[i]] = 1'b0;
      wr_reg(ADDR_FLAGS, fl);
      isr_ret();
    end
    wr_reg(ADDR_LEVEL, 16'h0800);
    wr_reg(ADDR_FLAGS, 16'h0001);
    serve(16'h0003);
    wr_reg(ADDR_FLAGS, 16'h4000);
    serve(16'h0063);
    wr_reg(ADDR_FLAGS, 16'h0004);
    idle_chk(16'hFFFF, 16'h0003);
    rd_chk(ADDR_STATUS, 16'h00B3);
    isr_ret();
    idle_chk(16'hFFFF, 16'h0001);
    isr_ret();
    serve(16'h0043);
    wr_reg(ADDR_FLAGS, 16'h0000);
    isr_ret();
    wr_reg(ADDR_TRIG, 16'h0001);
    @(posedge clk);
    pins <= 6'h3D;
    serve(16'h0013);
    rd_chk(ADDR_FLAGS, 16'h0002);
    @(posedge clk);
    pins <= 6'h3F;
    repeat (12) @(posedge clk);
    isr_ret();
    @(posedge clk);
    pins <= 6'h3A;
    serve(16'h0003);
    rd_chk(ADDR_FLAGS, 16'h0004);
    isr_ret();
    serve(16'h0043);
    wr_reg(ADDR_FLAGS, 16'h0000);
    pins <= 6'h3F;
    isr_ret();
    @(posedge clk);
    fset.timer0_overflow_flag <= 1'b1;
    @(posedge clk);
    fset <= '0;
    serve(16'h000B);
    isr_ret();
    c0 = calls;
    wr_reg(ADDR_ENABLE, 16'h0FFF);
    wr_reg(ADDR_FLAGS, 16'h0100);
    idle_chk(16'h0000, 16'(c0));
    wr_reg(ADDR_FLAGS, 16'h0000);
    wr_reg(ADDR_ENABLE, 16'h8FFF);
    idle_chk(16'h0000, 16'(c0));
    @(posedge clk);
    blk <= 1;
    wr_reg(ADDR_FLAGS, 16'h0100);
    idle_chk(16'h0000, 16'(c0));
    @(posedge clk);
    blk <= 0;
    last <= 0;
    idle_chk(16'h0000, 16'(c0));
    @(posedge clk);
    last <= 1;
    serve(16'h002B);
    final_report();
  end
endmodule

// >>> verilog/irq_ctrl_pkg.sv
// Purpose: shared constants and types of the two-level vectored interrupt controller
// Assumes: four system clocks per machine cycle, 16-bit register port
// Notes:   flag and source numbering is used by the controller top level only
package irq_ctrl_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int unsigned SRC_COUNT      = 12;
  localparam int unsigned FLAG_COUNT     = 15;
  localparam int unsigned EXT_COUNT      = 6;
  localparam int unsigned SRC_IDX_W      = 4;
  localparam int unsigned ADDR_W         = 3;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned CLKS_PER_MC    = 4;
  localparam int unsigned CALL_MCS       = 4;
  localparam int unsigned MIN_LATENCY_MC = 5;
  localparam int unsigned MAX_LATENCY_MC = 12;
  localparam int unsigned MAX_LATENCY_CLKS = MAX_LATENCY_MC * CLKS_PER_MC;
  localparam logic [1:0]  PHASE_SAMPLE   = 2'h0;
  localparam logic [1:0]  PHASE_THREE    = 2'h2;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;

  // ==========================================================================
  // Register offsets and fields
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_TRIG   = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;
  localparam int unsigned       GATE_BIT    = 15;
  localparam int unsigned       ST_LOW_SVC  = 0;
  localparam int unsigned       ST_HIGH_SVC = 1;
  localparam int unsigned       ST_BUSY     = 2;
  localparam int unsigned       ST_SRC_LSB  = 4;
  localparam logic [DATA_W-1:0] ENABLE_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] LEVEL_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] FLAGS_RST   = 16'h0000;
  localparam logic [1:0]        TRIG_RST    = 2'h0;

  // ==========================================================================
  // Flag positions
  localparam int unsigned F_EXT0  = 0;
  localparam int unsigned F_EXT1  = 1;
  localparam int unsigned F_EXT2  = 2;
  localparam int unsigned F_T0    = 6;
  localparam int unsigned F_T1    = 7;
  localparam int unsigned F_T2W   = 8;
  localparam int unsigned F_T2E   = 9;
  localparam int unsigned F_RX0   = 10;
  localparam int unsigned F_TX0   = 11;
  localparam int unsigned F_RX1   = 12;
  localparam int unsigned F_TX1   = 13;
  localparam int unsigned F_WDOG  = 14;

  // Source positions, index 0 wins ties
  localparam logic [SRC_IDX_W-1:0] S_EXT0 = 4'h0;
  localparam logic [SRC_IDX_W-1:0] S_T0   = 4'h1;
  localparam logic [SRC_IDX_W-1:0] S_EXT1 = 4'h2;
  localparam logic [SRC_IDX_W-1:0] S_T1   = 4'h3;

  localparam logic [SRC_COUNT-1:0][15:0] VECTOR_TABLE = {
    16'h0063, 16'h005B, 16'h0053, 16'h004B, 16'h0043, 16'h003B,
    16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

  // ==========================================================================
  // Types
  typedef struct packed {
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_wrap_flag;
    logic timer2_ext_flag;
    logic receive_done_flag;
    logic transmit_done_flag;
    logic receive1_done_flag;
    logic transmit1_done_flag;
    logic watchdog_due_flag;
  } flag_set_t;

  typedef struct packed {
    logic        push;
    logic [7:0]  push_data;
    logic        pc_load;
    logic [15:0] pc_value;
  } call_bus_t;

  typedef enum logic [2:0] {
    CALL_IDLE    = 3'h0,
    CALL_SAVE_LO = 3'h1,
    CALL_SAVE_HI = 3'h3,
    CALL_FETCH   = 3'h2,
    CALL_LOAD    = 3'h6
  } call_state_t;

endpackage

// >>> verilog/pin_sampler.sv
// Purpose: synchronise one external request pin and sample it once per machine cycle
// Assumes: pin is asynchronous to clk_i
// Notes:   fall_o marks a high sample followed by a low sample
`timescale 1ns/10ps
module pin_sampler (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  input  wire logic sample_en_i,
  output logic      level_o,
  output logic      fall_o
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic filt_reg;
  logic prev_reg;

  // ==========================================================================
  // Three-stage synchroniser, change accepted when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      filt_reg <= 1'b1;
    end else if (sync2_reg == sync3_reg) begin
      filt_reg <= sync3_reg;
    end
  end

  // ==========================================================================
  // Machine-cycle sample
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev_reg <= 1'b1;
    end else if (sample_en_i) begin
      prev_reg <= filt_reg;
    end
  end

  assign level_o = filt_reg;
  assign fall_o  = sample_en_i & prev_reg & ~filt_reg;

endmodule

// >>> verilog/prio_pick.sv
// Purpose: fixed-order picker, lowest index wins
// Assumes: request vector is already gated
// Notes:   purely combinational
`timescale 1ns/10ps
module prio_pick #(
  parameter int unsigned N     = 12,
  parameter int unsigned IDX_W = 4
) (
  input  wire logic [N-1:0]     req_i,
  output logic                  found_o,
  output logic [IDX_W-1:0]      idx_o
);

  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o   = IDX_W'(i);
      end
    end
  end

endmodule

// >>> verilog/two_level_vectored_irq_ctrl.sv
// Purpose: two-level, twelve-source vectored interrupt controller
// Assumes: core sequencer reports final machine cycle, return-from-interrupt and pc
// Notes:   four clocks per machine cycle; hardware call spans four machine cycles
`timescale 1ns/10ps
module two_level_vectored_irq_ctrl (
  input  wire logic                              clk_i,
  input  wire logic                              reset_n_i,
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [irq_ctrl_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic [irq_ctrl_pkg::DATA_W-1:0]        rdata_o,
  input  wire logic [irq_ctrl_pkg::EXT_COUNT-1:0] ext_irq_pin_n_i,
  input  wire irq_ctrl_pkg::flag_set_t           flag_set_i,
  input  wire logic                              last_cycle_i,
  input  wire logic                              blocking_instr_i,
  input  wire logic                              isr_exit_i,
  input  wire logic [15:0]                       pc_i,
  output logic [1:0]                             mc_phase_o,
  output irq_ctrl_pkg::call_bus_t                call_o,
  output logic                                   call_busy_o,
  output logic [1:0]                             in_service_o
);
  import irq_ctrl_pkg::*;

  // ==========================================================================
  // Declarations
  logic [1:0]            phase_reg;
  logic                  mc_end;
  logic                  phase_three;
  logic                  phase_sample;
  logic [DATA_W-1:0]     enable_reg;
  logic [SRC_COUNT-1:0]  level_reg;
  logic [1:0]            trig_reg;
  logic [FLAG_COUNT-1:0] flags_reg;
  logic [FLAG_COUNT-1:0] flags_next;
  logic [SRC_COUNT-1:0]  src_req;
  logic [SRC_COUNT-1:0]  sample_reg;
  logic [SRC_COUNT-1:0]  gated;
  logic [SRC_COUNT-1:0]  high_req;
  logic [SRC_COUNT-1:0]  low_req;
  logic                  high_found;
  logic                  low_found;
  logic [SRC_IDX_W-1:0]  high_idx;
  logic [SRC_IDX_W-1:0]  low_idx;
  logic                  pick_high;
  logic                  pick_low;
  logic [SRC_IDX_W-1:0]  pick_idx;
  logic                  prio_write_now;
  logic                  prio_write_reg;
  logic                  exit_seen_reg;
  logic                  blocked;
  logic                  take;
  logic [1:0]            in_svc_reg;
  logic [SRC_IDX_W-1:0]  last_src_reg;
  logic [15:0]           vector_reg;
  logic [15:0]           ret_pc_reg;
  call_state_t           call_state_reg;
  call_state_t           call_state_next;
  call_bus_t             call_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [EXT_COUNT-1:0]  pin_level;
  logic [EXT_COUNT-1:0]  pin_fall;

  // ==========================================================================
  // Machine-cycle phase divider
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase_reg <= PHASE_SAMPLE;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign mc_end       = (phase_reg == PHASE_LAST);
  assign phase_three  = (phase_reg == PHASE_THREE);
  assign phase_sample = (phase_reg == PHASE_SAMPLE);
  assign mc_phase_o   = phase_reg;

  // ==========================================================================
  // External request pins
  for (genvar g = 0; g < EXT_COUNT; g++) begin : g_pin
    pin_sampler u_pin (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .pin_i       (ext_irq_pin_n_i[g]),
      .sample_en_i (phase_three),
      .level_o     (pin_level[g]),
      .fall_o      (pin_fall[g])
    );
  end

  // ==========================================================================
  // Register port writes
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enable_reg <= ENABLE_RST;
    end else if (wr_i && addr_i == ADDR_ENABLE) begin
      enable_reg <= wdata_i & {1'b1, 3'h0, {SRC_COUNT{1'b1}}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      level_reg <= LEVEL_RST[SRC_COUNT-1:0];
    end else if (wr_i && addr_i == ADDR_LEVEL) begin
      level_reg <= wdata_i[SRC_COUNT-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      trig_reg <= TRIG_RST;
    end else if (wr_i && addr_i == ADDR_TRIG) begin
      trig_reg <= wdata_i[1:0];
    end
  end

  // ==========================================================================
  // Request flags
  always_comb begin
    flags_next = flags_reg;
    if (wr_i && addr_i == ADDR_FLAGS) begin
      flags_next = wdata_i[FLAG_COUNT-1:0];
    end
    if (take) begin
      if (pick_idx == S_T0) begin
        flags_next[F_T0] = 1'b0;
      end
      if (pick_idx == S_T1) begin
        flags_next[F_T1] = 1'b0;
      end
      if (pick_idx == S_EXT0 && trig_reg[0]) begin
        flags_next[F_EXT0] = 1'b0;
      end
      if (pick_idx == S_EXT1 && trig_reg[1]) begin
        flags_next[F_EXT1] = 1'b0;
      end
    end
    if (phase_three) begin
      for (int i = 0; i < 2; i++) begin
        if (trig_reg[i]) begin
          flags_next[F_EXT0 + i] = flags_next[F_EXT0 + i] | pin_fall[i];
        end else begin
          flags_next[F_EXT0 + i] = ~pin_level[i];
        end
      end
      for (int i = 2; i < EXT_COUNT; i++) begin
        flags_next[F_EXT2 + i - 2] = flags_next[F_EXT2 + i - 2] | pin_fall[i];
      end
    end
    // Hardware set wins over any clear in the same clock
    flags_next[F_T0]   = flags_next[F_T0]   | flag_set_i.timer0_overflow_flag;
    flags_next[F_T1]   = flags_next[F_T1]   | flag_set_i.timer1_overflow_flag;
    flags_next[F_T2W]  = flags_next[F_T2W]  | flag_set_i.timer2_wrap_flag;
    flags_next[F_T2E]  = flags_next[F_T2E]  | flag_set_i.timer2_ext_flag;
    flags_next[F_RX0]  = flags_next[F_RX0]  | flag_set_i.receive_done_flag;
    flags_next[F_TX0]  = flags_next[F_TX0]  | flag_set_i.transmit_done_flag;
    flags_next[F_RX1]  = flags_next[F_RX1]  | flag_set_i.receive1_done_flag;
    flags_next[F_TX1]  = flags_next[F_TX1]  | flag_set_i.transmit1_done_flag;
    flags_next[F_WDOG] = flags_next[F_WDOG] | flag_set_i.watchdog_due_flag;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flags_reg <= FLAGS_RST[FLAG_COUNT-1:0];
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================================
  // Per-source requests in fixed tie order
  always_comb begin
    src_req = '0;
    src_req[0]  = flags_reg[F_EXT0];
    src_req[1]  = flags_reg[F_T0];
    src_req[2]  = flags_reg[F_EXT1];
    src_req[3]  = flags_reg[F_T1];
    src_req[4]  = flags_reg[F_RX0] | flags_reg[F_TX0];
    src_req[5]  = flags_reg[F_T2W] | flags_reg[F_T2E];
    src_req[6]  = flags_reg[F_RX1] | flags_reg[F_TX1];
    src_req[7]  = flags_reg[F_EXT2];
    src_req[8]  = flags_reg[F_EXT2 + 1];
    src_req[9]  = flags_reg[F_EXT2 + 2];
    src_req[10] = flags_reg[F_EXT2 + 3];
    src_req[11] = flags_reg[F_WDOG];
  end

  // Sample at the first clock; flags set at phase three land in the next cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sample_reg <= '0;
    end else if (phase_sample) begin
      sample_reg <= src_req;
    end
  end

  // ==========================================================================
  // Polling and priority resolution
  assign gated    = sample_reg & enable_reg[SRC_COUNT-1:0]
                    & {SRC_COUNT{enable_reg[GATE_BIT]}};
  assign high_req = gated & level_reg;
  assign low_req  = gated & ~level_reg;

  prio_pick #(
    .N     (SRC_COUNT),
    .IDX_W (SRC_IDX_W)
  ) u_pick_high (
    .req_i   (high_req),
    .found_o (high_found),
    .idx_o   (high_idx)
  );

  prio_pick #(
    .N     (SRC_COUNT),
    .IDX_W (SRC_IDX_W)
  ) u_pick_low (
    .req_i   (low_req),
    .found_o (low_found),
    .idx_o   (low_idx)
  );

  assign pick_high = high_found & ~in_svc_reg[1];
  assign pick_low  = ~pick_high & low_found & (in_svc_reg == 2'h0);
  assign pick_idx  = pick_high ? high_idx : low_idx;

  // ==========================================================================
  // Blocking instructions within the current machine cycle
  assign prio_write_now = wr_i & ((addr_i == ADDR_ENABLE) | (addr_i == ADDR_LEVEL));

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prio_write_reg <= 1'b0;
    end else begin
      prio_write_reg <= prio_write_now | (prio_write_reg & ~mc_end);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      exit_seen_reg <= 1'b0;
    end else begin
      exit_seen_reg <= isr_exit_i | (exit_seen_reg & ~mc_end);
    end
  end

  assign blocked = prio_write_now | prio_write_reg | exit_seen_reg | isr_exit_i
                   | blocking_instr_i;

  // Decision from this cycle's sample only; nothing carries over
  assign take = mc_end & last_cycle_i & ~blocked & ~call_busy_o
                & (pick_high | pick_low);

  // ==========================================================================
  // In-service markers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      in_svc_reg <= 2'h0;
    end else if (take) begin
      if (pick_high) begin
        in_svc_reg[1] <= 1'b1;
      end else begin
        in_svc_reg[0] <= 1'b1;
      end
    end else if (isr_exit_i) begin
      if (in_svc_reg[1]) begin
        in_svc_reg[1] <= 1'b0;
      end else begin
        in_svc_reg[0] <= 1'b0;
      end
    end
  end
  // A plain subroutine return has no input here, so markers stay set

  assign in_service_o = in_svc_reg;

  // ==========================================================================
  // Captured vector and return address
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      vector_reg   <= 16'h0000;
      ret_pc_reg   <= 16'h0000;
      last_src_reg <= 4'h0;
    end else if (take) begin
      vector_reg   <= VECTOR_TABLE[pick_idx];
      ret_pc_reg   <= pc_i;
      last_src_reg <= pick_idx;
    end
  end

  // ==========================================================================
  // Hardware long call, one state per machine cycle
  always_comb begin
    call_state_next = call_state_reg;
    case (call_state_reg)
      CALL_IDLE: begin
        if (take) begin
          call_state_next = CALL_SAVE_LO;
        end
      end
      CALL_SAVE_LO: begin
        if (mc_end) begin
          call_state_next = CALL_SAVE_HI;
        end
      end
      CALL_SAVE_HI: begin
        if (mc_end) begin
          call_state_next = CALL_FETCH;
        end
      end
      CALL_FETCH: begin
        if (mc_end) begin
          call_state_next = CALL_LOAD;
        end
      end
      CALL_LOAD: begin
        if (mc_end) begin
          call_state_next = CALL_IDLE;
        end
      end
      default: begin
        call_state_next = CALL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      call_state_reg <= CALL_IDLE;
    end else begin
      call_state_reg <= call_state_next;
    end
  end

  assign call_busy_o = (call_state_reg != CALL_IDLE);

  // Low byte pushed first, status word never touched
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      call_reg <= '0;
    end else begin
      call_reg.push      <= 1'b0;
      call_reg.pc_load   <= 1'b0;
      if (mc_end && call_state_reg == CALL_SAVE_LO) begin
        call_reg.push      <= 1'b1;
        call_reg.push_data <= ret_pc_reg[7:0];
      end
      if (mc_end && call_state_reg == CALL_SAVE_HI) begin
        call_reg.push      <= 1'b1;
        call_reg.push_data <= ret_pc_reg[15:8];
      end
      if (mc_end && call_state_reg == CALL_LOAD) begin
        call_reg.pc_load   <= 1'b1;
        call_reg.pc_value  <= vector_reg;
      end
    end
  end

  assign call_o = call_reg;

  // ==========================================================================
  // Register port reads, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_ENABLE: rdata_reg <= enable_reg;
        ADDR_LEVEL:  rdata_reg <= {4'h0, level_reg};
        ADDR_FLAGS:  rdata_reg <= {1'b0, flags_reg};
        ADDR_TRIG:   rdata_reg <= {14'h0000, trig_reg};
        ADDR_STATUS: rdata_reg <= {8'h00, last_src_reg, 1'b0, call_busy_o, in_svc_reg};
        default:     rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign rdata_o = rdata_reg;

endmodule
